// ==== dv/dsbp_host_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host controller model: input clocks, output clocks, command pins
// ----------------------------------------------------------------
module dsbp_host_model #(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 18
) (
    // clock
    input  wire logic              clk,
    // bench requests
    input  wire logic              k_run,
    input  wire logic              c_tied,
    input  wire logic              go,
    input  wire logic              rd,
    input  wire logic [ADDR_W-1:0] a,
    input  wire logic [DATA_W-1:0] d0,
    input  wire logic [DATA_W-1:0] d1,
    // device pins
    output logic                   sample_edge_pos,
    output logic                   sample_edge_neg,
    output logic                   output_timing_pos,
    output logic                   output_timing_neg,
    output logic                   load_n,
    output logic                   read_write_sel,
    output logic      [ADDR_W-1:0] addr,
    output logic      [DATA_W-1:0] wdata_rise,
    output logic      [DATA_W-1:0] wdata_fall
);
    logic              k_q       = 1'b0;
    logic [1:0]        c_q       = 2'h0;
    logic [ADDR_W-1:0] a_last_q  = '0;
    logic [DATA_W-1:0] d0_last_q = '0;
    logic [DATA_W-1:0] d1_last_q = '0;

    // input clock toggles each cycle and stands still when stopped;
    // a plain always, since these registers start from declared values
    always @(posedge clk) begin
        if (k_run) begin
            k_q <= ~k_q;
        end
        c_q <= c_q + 2'h1;
        if (go) begin
            a_last_q  <= a;
            d0_last_q <= d0;
            d1_last_q <= d1;
        end
    end

    // clocks: output pair runs at a quarter rate unless tied high
    assign sample_edge_pos   = k_q;
    assign sample_edge_neg   = ~k_q;
    assign output_timing_pos = c_tied | c_q[1];
    assign output_timing_neg = c_tied | ~c_q[1];

    // idle cycles keep load high; released buses show the inverse, never a stale copy
    assign load_n         = ~go;
    assign read_write_sel = go ? rd : ~rd;
    assign addr           = go ? a : ~a_last_q;
    assign wdata_rise     = go ? d0 : ~d0_last_q;
    assign wdata_fall     = go ? d1 : ~d1_last_q;
endmodule

// ==== dv/dsbp_port_tb.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// self-checking bench of the burst port
// ----------------------------------------------------------------
module dsbp_port_tb;
    logic        clk, rst, pll_bypass_n, supply_ok, k_run, c_tied, go, rd;
    logic [19:0] a;
    logic [17:0] d0, d1;
    logic        kp, kn, cp, cn, load_n, rws;
    logic [19:0] addr;
    logic [17:0] wr, wf, q_rise, q_fall;
    logic        q_valid, q_oe_n, echo_pos, echo_neg, pll_locked, pll_reset;
    logic [1:0]  read_latency;
    int          fails = 0;
    int          checks = 0;

    dsbp_host_model i_host (.clk(clk), .k_run(k_run), .c_tied(c_tied), .go(go), .rd(rd), .a(a), .d0(d0),
        .d1(d1), .sample_edge_pos(kp), .sample_edge_neg(kn), .output_timing_pos(cp), .output_timing_neg(cn),
        .load_n(load_n), .read_write_sel(rws), .addr(addr), .wdata_rise(wr), .wdata_fall(wf));

    dsbp_port i_dut (.clk(clk), .rst(rst), .pll_bypass_n(pll_bypass_n), .supply_ok(supply_ok),
        .sample_edge_pos(kp), .sample_edge_neg(kn), .output_timing_pos(cp), .output_timing_neg(cn),
        .load_n(load_n), .read_write_sel(rws), .addr(addr), .wdata_rise(wr), .wdata_fall(wf),
        .q_rise(q_rise), .q_fall(q_fall), .q_valid(q_valid), .q_oe_n(q_oe_n), .echo_pos(echo_pos),
        .echo_neg(echo_neg), .read_latency(read_latency), .pll_locked(pll_locked), .pll_reset(pll_reset));

    // clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // command is presented now and taken at the next edge
    task automatic issue(input logic r, input logic [19:0] aa, input logic [17:0] x0, input logic [17:0] x1);
        @(posedge clk);
        go <= 1'b1;
        rd <= r;
        a  <= aa;
        d0 <= x0;
        d1 <= x1;
    endtask

    // takes the last read, then follows its burst and the turn-off
    task automatic rd_chk(input int lat, input logic [17:0] e0, input logic [17:0] e1);
        @(posedge clk);
        go <= 1'b0;
        #1;
        chk(q_oe_n, 0);
        if (lat == 2) begin
            @(posedge clk);
            #1;
        end
        chk(q_valid, 1);
        chk(q_rise, e0);
        chk(q_fall, e1);
        @(posedge clk);
        #1;
        chk(q_valid, 0);
        chk(q_oe_n, 0);
        repeat (3 - lat) @(posedge clk);
        #1;
        chk(q_oe_n, 1);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_lock;
        int n;
        n = 0;
        chk({q_valid, q_oe_n, pll_reset, pll_locked, read_latency}, 32'h1a);
        @(posedge clk);
        supply_ok <= 1'b1;
        repeat (1100) @(posedge clk);
        #1;
        chk(pll_locked, 0);
        @(posedge clk);
        k_run <= 1'b1; // load stays high throughout the lock
        while (pll_locked !== 1'b1 && n < 1200) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n >= dsbp_pkg::LOCK_CYCLES && n <= dsbp_pkg::LOCK_CYCLES + 8, 1);
        chk(pll_reset, 0);
    endtask

    // echo follows the output pair, or the input pair when that is tied high
    task automatic t_echo(input logic tied, input int exp);
        int   n;
        logic prev;
        n = 0;
        @(posedge clk);
        c_tied <= tied;
        repeat (5) @(posedge clk);
        #1;
        prev = echo_pos;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (echo_pos !== prev) n++;
            prev = echo_pos;
        end
        chk(n, exp);
        chk(echo_neg, !echo_pos);
    endtask

    task automatic t_data;
        issue(0, 20'h00040, 18'h1a5a5, 18'h25a5a);
        issue(1, 20'h00040, 18'h0, 18'h0);
        rd_chk(2, 18'h1a5a5, 18'h25a5a);
        // partial overlap with the write just before: head word, then tail word
        issue(0, 20'h00041, 18'h0aaaa, 18'h15555);
        issue(1, 20'h00040, 18'h0, 18'h0);
        rd_chk(2, 18'h1a5a5, 18'h0aaaa);
        issue(0, 20'h0003f, 18'h03333, 18'h04444);
        issue(1, 20'h00040, 18'h0, 18'h0);
        rd_chk(2, 18'h04444, 18'h0aaaa);
        issue(0, 20'hfffff, 18'h01234, 18'h05678);
        issue(0, 20'h00001, 18'h09abc, 18'h0def0);
        issue(1, 20'hfffff, 18'h0, 18'h0);
        rd_chk(2, 18'h01234, 18'h05678);
        issue(1, 20'h00000, 18'h0, 18'h0);
        rd_chk(2, 18'h05678, 18'h09abc);
    endtask

    task automatic t_bypass;
        @(posedge clk);
        pll_bypass_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk(read_latency, 1);
        chk(pll_reset, 1);
        issue(0, 20'h00300, 18'h3c3c3, 18'h03c3c);
        issue(1, 20'h00300, 18'h0, 18'h0);
        rd_chk(1, 18'h3c3c3, 18'h03c3c);
        @(posedge clk);
        pll_bypass_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(read_latency, 2);
    endtask

    task automatic t_stop;
        int n;
        n = 0;
        @(posedge clk);
        k_run <= 1'b0;
        while (pll_reset !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n <= 6, 1);
        chk(pll_locked, 0);
    endtask

    // watchdog: the tests need about 2200 cycles
    initial begin
        #200000;
        fails++;
        end_sim();
    end

    // main sequence
    initial begin
        rst = 1'b1;
        pll_bypass_n = 1'b1;
        supply_ok = 1'b0;
        k_run = 1'b0;
        c_tied = 1'b0;
        go = 1'b0;
        rd = 1'b0;
        a = '0;
        d0 = '0;
        d1 = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        t_lock();
        t_echo(1'b0, 4);
        t_echo(1'b1, 8);
        t_data();
        t_bypass();
        t_stop();
        end_sim();
    end
endmodule

// ==== src/dsbp_array.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// storage array: two-word write, two-word read
// ----------------------------------------------------------------
module dsbp_array #(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 18
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // write side
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] waddr,
    input  wire logic [DATA_W-1:0] wd0,
    input  wire logic [DATA_W-1:0] wd1,
    // read side
    input  wire logic [ADDR_W-1:0] raddr,
    output logic      [DATA_W-1:0] rd0,
    output logic      [DATA_W-1:0] rd1
);

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [ADDR_W-1:0] waddr1;
    logic [ADDR_W-1:0] raddr1;

    // burst counter: second word lives at the next address, wrapping
    assign waddr1 = ADDR_W'(waddr + 1'b1);
    assign raddr1 = ADDR_W'(raddr + 1'b1);

    // no reset on the array, contents are undefined after power-up
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr]  <= wd0;
            mem[waddr1] <= wd1;
        end
    end

    // asynchronous read, registered by the caller
    assign rd0 = mem[raddr];
    assign rd1 = mem[raddr1];

    a_burst_order: assert property (@(posedge clk) disable iff (rst)
        we ##1 (raddr == $past(waddr)) |-> (rd0 == $past(wd0)) && (rd1 == $past(wd1)))
        else $error("burst words not stored at address and address plus one");

endmodule

// ==== src/dsbp_pkg.sv ====
// ----------------------------------------------------------------
// shared constants of the burst port
// ----------------------------------------------------------------
package dsbp_pkg;

    // core clock
    localparam int CLK_PERIOD_NS  = 20;

    // read latency in clock cycles, with and without the pll
    localparam int READ_LAT_PLL   = 2;
    localparam int READ_LAT_BYP   = 1;

    // output turn-off after the last read, in half cycles (2.5 cycles)
    localparam int QZ_HALF_CYCLES = 5;
    localparam int QZ_CYCLES      = (QZ_HALF_CYCLES + 1) / 2;

    // static input clock time that resets the pll
    localparam int STOP_NS        = 30;
    localparam int STOP_CYCLES    = (STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // pll lock interval
    localparam int LOCK_US        = 20;
    localparam int LOCK_CYCLES    = (LOCK_US * 1000) / CLK_PERIOD_NS;

    // bit positions in the pin synchroniser vector
    localparam int PIN_BYPASS_N   = 0;
    localparam int PIN_SUPPLY     = 1;
    localparam int PIN_KPOS       = 2;
    localparam int PIN_KNEG       = 3;
    localparam int PIN_CPOS       = 4;
    localparam int PIN_CNEG       = 5;
    localparam int PIN_COUNT      = 6;

    // synchroniser reset value: bypass pin reads as released
    localparam logic [PIN_COUNT-1:0] SYNC_RST = 6'h01;

    // pll control states
    typedef enum logic [1:0] {
        PLL_RESET   = 2'b00,
        PLL_LOCKING = 2'b01,
        PLL_LOCKED  = 2'b10
    } dsbp_pll_e;

endpackage

// ==== src/dsbp_port.sv ====
`timescale 1ns/1ps
// Contract
// - with the bypass pin low the pll is unused and read latency becomes one cycle.
// - the lock interval starts only once supply and input clock are both stable.
// - the device watches the positive input clock and resets its pll when it stops.
// - an input clock static for 30 ns or more counts as stopped; the code needs two 20 ns cycles (40 ns) without an edge.
// - every command, address and data input is sampled on each latching edge.
// - with both output timing inputs high, output timing follows the input clocks.
// - a read returns the word at the address first and the word at address plus one second.
// - read outputs go high impedance 2.5 cycles after the last read; the code rounds up and turns them off after 3 whole cycles.
// - load low with the select high is a read and starts a read burst.
// - a read of the address just written returns the written data, not the old contents.
module dsbp_port #(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 18
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // asynchronous pins
    input  wire logic              pll_bypass_n,
    input  wire logic              supply_ok,
    input  wire logic              sample_edge_pos,
    input  wire logic              sample_edge_neg,
    input  wire logic              output_timing_pos,
    input  wire logic              output_timing_neg,
    // command and write data
    input  wire logic              load_n,
    input  wire logic              read_write_sel,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata_rise,
    input  wire logic [DATA_W-1:0] wdata_fall,
    // read data
    output logic      [DATA_W-1:0] q_rise,
    output logic      [DATA_W-1:0] q_fall,
    output logic                   q_valid,
    output logic                   q_oe_n,
    // echo clocks and status
    output logic                   echo_pos,
    output logic                   echo_neg,
    output logic      [1:0]        read_latency,
    output logic                   pll_locked,
    output logic                   pll_reset
);

    localparam int PC = dsbp_pkg::PIN_COUNT;
    localparam logic [1:0] STOP_CNT  = 2'(dsbp_pkg::STOP_CYCLES);
    localparam logic [9:0] LOCK_LAST = 10'(dsbp_pkg::LOCK_CYCLES - 1);
    localparam logic [1:0] QZ_LOAD   = 2'(dsbp_pkg::QZ_CYCLES);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [PC-1:0] pins_raw;
    logic [PC-1:0] sync1_d, sync1_q;
    logic [PC-1:0] sync2_d, sync2_q;
    logic          bypass, supply_s, kpos_s, kneg_s, cpos_s, cneg_s;

    // gather the pins into one vector
    assign pins_raw[dsbp_pkg::PIN_BYPASS_N] = pll_bypass_n;
    assign pins_raw[dsbp_pkg::PIN_SUPPLY]   = supply_ok;
    assign pins_raw[dsbp_pkg::PIN_KPOS]     = sample_edge_pos;
    assign pins_raw[dsbp_pkg::PIN_KNEG]     = sample_edge_neg;
    assign pins_raw[dsbp_pkg::PIN_CPOS]     = output_timing_pos;
    assign pins_raw[dsbp_pkg::PIN_CNEG]     = output_timing_neg;

    // two stages, only the second one is read
    always_comb begin
        sync1_d = pins_raw;
        sync2_d = sync1_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= dsbp_pkg::SYNC_RST;
            sync2_q <= dsbp_pkg::SYNC_RST;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    // synchronised pin levels
    assign bypass   = ~sync2_q[dsbp_pkg::PIN_BYPASS_N];
    assign supply_s = sync2_q[dsbp_pkg::PIN_SUPPLY];
    assign kpos_s   = sync2_q[dsbp_pkg::PIN_KPOS];
    assign kneg_s   = sync2_q[dsbp_pkg::PIN_KNEG];
    assign cpos_s   = sync2_q[dsbp_pkg::PIN_CPOS];
    assign cneg_s   = sync2_q[dsbp_pkg::PIN_CNEG];

    // ------------------------------------------------------------
    // pll control: stop detect and lock interval
    // ------------------------------------------------------------
    dsbp_pkg::dsbp_pll_e pll_d, pll_q;
    logic [9:0]          lock_cnt_d, lock_cnt_q;
    logic [1:0]          stat_cnt_d, stat_cnt_q;
    logic                kpos_last_d, kpos_last_q;
    logic                clk_stopped;
    logic                pll_bad;

    assign clk_stopped = (stat_cnt_q >= STOP_CNT);
    assign pll_bad     = bypass | ~supply_s | clk_stopped;

    // count cycles without an edge; the pll itself is off in bypass
    always_comb begin
        kpos_last_d = kpos_s;
        stat_cnt_d  = stat_cnt_q;
        pll_d       = pll_q;
        lock_cnt_d  = lock_cnt_q;
        if (kpos_s != kpos_last_q) begin
            stat_cnt_d = 2'h0;
        end else if (stat_cnt_q != 2'h3) begin
            stat_cnt_d = 2'(stat_cnt_q + 2'h1);
        end
        unique case (pll_q)
            dsbp_pkg::PLL_RESET: begin
                lock_cnt_d = 10'h000;
                if (!pll_bad) begin
                    pll_d = dsbp_pkg::PLL_LOCKING;
                end
            end
            dsbp_pkg::PLL_LOCKING: begin
                if (pll_bad) begin
                    pll_d = dsbp_pkg::PLL_RESET;
                end else if (lock_cnt_q == LOCK_LAST) begin
                    pll_d = dsbp_pkg::PLL_LOCKED;
                end else begin
                    lock_cnt_d = 10'(lock_cnt_q + 10'h001);
                end
            end
            dsbp_pkg::PLL_LOCKED: begin
                if (pll_bad) begin
                    pll_d = dsbp_pkg::PLL_RESET;
                end
            end
            default: pll_d = dsbp_pkg::PLL_RESET;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pll_q       <= dsbp_pkg::PLL_RESET;
            lock_cnt_q  <= 10'h000;
            stat_cnt_q  <= 2'h3;
            kpos_last_q <= 1'b0;
        end else begin
            pll_q       <= pll_d;
            lock_cnt_q  <= lock_cnt_d;
            stat_cnt_q  <= stat_cnt_d;
            kpos_last_q <= kpos_last_d;
        end
    end

    assign pll_locked   = (pll_q == dsbp_pkg::PLL_LOCKED);
    assign pll_reset    = (pll_q == dsbp_pkg::PLL_RESET);
    assign read_latency = bypass ? 2'(dsbp_pkg::READ_LAT_BYP) : 2'(dsbp_pkg::READ_LAT_PLL);

    // ------------------------------------------------------------
    // command decode, write buffer and forwarding
    // ------------------------------------------------------------
    logic              rd_cmd, wr_cmd;
    logic              wpend_d, wpend_q;
    logic [ADDR_W-1:0] wbuf_addr_d, wbuf_addr_q;
    logic [DATA_W-1:0] wbuf_rise_d, wbuf_rise_q;
    logic [DATA_W-1:0] wbuf_fall_d, wbuf_fall_q;
    logic [ADDR_W-1:0] addr1, wbuf_addr1;
    logic [DATA_W-1:0] mem_rd0, mem_rd1;
    logic [DATA_W-1:0] rd_word0, rd_word1;

    assign rd_cmd     = ~load_n & read_write_sel;
    assign wr_cmd     = ~load_n & ~read_write_sel;
    assign addr1      = ADDR_W'(addr + 1'b1);
    assign wbuf_addr1 = ADDR_W'(wbuf_addr_q + 1'b1);

    // writes land in the array one edge late, so the next read may need them
    always_comb begin
        wpend_d     = wr_cmd;
        wbuf_addr_d = wbuf_addr_q;
        wbuf_rise_d = wbuf_rise_q;
        wbuf_fall_d = wbuf_fall_q;
        if (wr_cmd) begin
            wbuf_addr_d = addr;
            wbuf_rise_d = wdata_rise;
            wbuf_fall_d = wdata_fall;
        end
        rd_word0 = mem_rd0;
        rd_word1 = mem_rd1;
        if (wpend_q && addr == wbuf_addr_q) begin
            rd_word0 = wbuf_rise_q;
            rd_word1 = wbuf_fall_q;
        end else if (wpend_q && addr == wbuf_addr1) begin
            rd_word0 = wbuf_fall_q; // partial overlap, tail word
        end else if (wpend_q && addr1 == wbuf_addr_q) begin
            rd_word1 = wbuf_rise_q; // partial overlap, head word
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wpend_q     <= 1'b0;
            wbuf_addr_q <= '0;
            wbuf_rise_q <= '0;
            wbuf_fall_q <= '0;
        end else begin
            wpend_q     <= wpend_d;
            wbuf_addr_q <= wbuf_addr_d;
            wbuf_rise_q <= wbuf_rise_d;
            wbuf_fall_q <= wbuf_fall_d;
        end
    end

    // array reads address and address plus one in one cycle
    dsbp_array #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W)
    ) u_array (
        .clk   (clk),
        .rst   (rst),
        .we    (wpend_q),
        .waddr (wbuf_addr_q),
        .wd0   (wbuf_rise_q),
        .wd1   (wbuf_fall_q),
        .raddr (addr),
        .rd0   (mem_rd0),
        .rd1   (mem_rd1)
    );

    // ------------------------------------------------------------
    // read pipeline, output enable and echo clocks
    // ------------------------------------------------------------
    logic              s1_valid_d, s1_valid_q;
    logic [DATA_W-1:0] s1_rise_d, s1_rise_q, s1_fall_d, s1_fall_q;
    logic              qv_d, qv_q;
    logic [DATA_W-1:0] qr_d, qr_q, qf_d, qf_q;
    logic [1:0]        hz_cnt_d, hz_cnt_q;
    logic              echo_pos_d, echo_pos_q, echo_neg_d, echo_neg_q;
    logic              echo_from_k;

    assign echo_from_k = cpos_s & cneg_s;

    // bypass skips the extra stage; data holds between bursts
    always_comb begin
        s1_valid_d = rd_cmd;
        s1_rise_d  = rd_cmd ? rd_word0 : s1_rise_q;
        s1_fall_d  = rd_cmd ? rd_word1 : s1_fall_q;
        qr_d       = qr_q;
        qf_d       = qf_q;
        if (bypass) begin
            qv_d = rd_cmd;
            if (rd_cmd) begin
                qr_d = rd_word0;
                qf_d = rd_word1;
            end
        end else begin
            qv_d = s1_valid_q;
            if (s1_valid_q) begin
                qr_d = s1_rise_q;
                qf_d = s1_fall_q;
            end
        end
        hz_cnt_d = hz_cnt_q;
        if (rd_cmd) begin
            hz_cnt_d = QZ_LOAD;
        end else if (hz_cnt_q != 2'h0) begin
            hz_cnt_d = 2'(hz_cnt_q - 2'h1);
        end
        echo_pos_d = echo_from_k ? kpos_s : cpos_s;
        echo_neg_d = echo_from_k ? kneg_s : cneg_s;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_valid_q <= 1'b0;
            s1_rise_q  <= '0;
            s1_fall_q  <= '0;
            qv_q       <= 1'b0;
            qr_q       <= '0;
            qf_q       <= '0;
            hz_cnt_q   <= 2'h0;
            echo_pos_q <= 1'b0;
            echo_neg_q <= 1'b0;
        end else begin
            s1_valid_q <= s1_valid_d;
            s1_rise_q  <= s1_rise_d;
            s1_fall_q  <= s1_fall_d;
            qv_q       <= qv_d;
            qr_q       <= qr_d;
            qf_q       <= qf_d;
            hz_cnt_q   <= hz_cnt_d;
            echo_pos_q <= echo_pos_d;
            echo_neg_q <= echo_neg_d;
        end
    end

    // turn-off is a count, not tied to the data beat, so it covers both latencies
    assign q_valid  = qv_q;
    assign q_rise   = qr_q;
    assign q_fall   = qf_q;
    assign q_oe_n   = (hz_cnt_q == 2'h0);
    assign echo_pos = echo_pos_q;
    assign echo_neg = echo_neg_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_byp_latency: assert property (bypass && rd_cmd |=> q_valid)
        else $error("bypass read not answered after one cycle");
    a_pll_latency: assert property ((!bypass && rd_cmd) ##1 !bypass |=> q_valid)
        else $error("pll read not answered after two cycles");
    a_lock_start: assert property ($rose(pll_q == dsbp_pkg::PLL_LOCKING) |-> $past(supply_s && !clk_stopped))
        else $error("lock interval started before supply and clock were stable");
    a_lock_length: assert property ($rose(pll_locked) |-> $past(lock_cnt_q) == LOCK_LAST)
        else $error("pll locked before the full lock interval");
    a_stop_reset: assert property ($stable(kpos_s) [*3] |=> pll_reset)
        else $error("static input clock did not reset the pll");
    a_echo_source: assert property (echo_from_k |=> echo_pos == $past(kpos_s) && echo_neg == $past(kneg_s))
        else $error("echo clocks not taken from input clocks");
    a_hiz_after: assert property (rd_cmd ##1 !rd_cmd [*3] |=> q_oe_n)
        else $error("outputs still driven after turn-off time");
    a_drive_window: assert property (rd_cmd |=> !q_oe_n [*3])
        else $error("outputs released too early after a read");
    a_idle_quiet: assert property (!rd_cmd [*2] |=> !q_valid)
        else $error("read data without a read command");
    a_fwd_exact: assert property (bypass && rd_cmd && wpend_q && addr == wbuf_addr_q |=>
        q_rise == $past(wbuf_rise_q) && q_fall == $past(wbuf_fall_q))
        else $error("written data not forwarded to following read");
    a_write_capture: assert property (wr_cmd |=> wpend_q && wbuf_addr_q == $past(addr)
        && wbuf_rise_q == $past(wdata_rise) && wbuf_fall_q == $past(wdata_fall))
        else $error("write command or data not sampled");

endmodule
